// ### rtl/pic_pkg.sv
// Shared constants and types of the prioritized interrupt controller.
package pic_pkg;
   // =========================================================
   // Sizes
   localparam int NUM_SRC = 32; // RL14
   localparam int ID_W = 5;
   localparam int PRIO_BITS = 3; // RL14
   localparam int PRIO_FIELD_W = 8;
   localparam int PRIO_LOW_W = PRIO_FIELD_W - PRIO_BITS;
   localparam int EVT_W = 3;
   localparam logic [2:0] PB_MAX = 3'h3;
   localparam logic [3:0] RUN_IDLE = 4'h8;
   localparam logic [PRIO_LOW_W-1:0] PRIO_LOW_ZERO = 5'h00;
   localparam logic [NUM_SRC-1:0] ONE_SRC = 32'h1;

   // =========================================================
   // Register offsets
   localparam logic [7:0] OFF_ENABLE = 8'h00;
   localparam logic [7:0] OFF_ENSET = 8'h04;
   localparam logic [7:0] OFF_ENCLR = 8'h08;
   localparam logic [7:0] OFF_PENDSET = 8'h0c;
   localparam logic [7:0] OFF_PENDCLR = 8'h10;
   localparam logic [7:0] OFF_ACTIVE = 8'h14;
   localparam logic [7:0] OFF_MASTER = 8'h18;
   localparam logic [7:0] OFF_GROUP = 8'h1c;
   localparam logic [7:0] OFF_THRESH = 8'h20;
   localparam logic [7:0] OFF_EVTSTAT = 8'h24;
   localparam logic [7:0] OFF_EVTMASK = 8'h28;
   localparam int PRIO_SEL_BIT = 7;
   localparam int PRIO_IDX_MSB = 6;
   localparam int PRIO_IDX_LSB = 2;

   // =========================================================
   // Field positions
   localparam int MASTER_MASK_BIT = 0;
   localparam int GROUP_MSB = 2;
   localparam int PRIO_HI_MSB = 7;
   localparam int PRIO_HI_LSB = 5;
   localparam int EVT_DISPATCH = 0;
   localparam int EVT_BADEOI = 1;
   localparam int EVT_OVERRUN = 2;

   // =========================================================
   // Controller state, all fields reset to zero
   typedef struct packed {
      logic [NUM_SRC-1:0] enable;
      logic [NUM_SRC-1:0] pending;
      logic [NUM_SRC-1:0] active;
      logic [NUM_SRC-1:0] srcPrev;
      logic [NUM_SRC-1:0][PRIO_BITS-1:0] prio;
      logic masterMask;
      logic masterPrev;
      logic [2:0] groupBits;
      logic [PRIO_BITS-1:0] thresh;
      logic [EVT_W-1:0] evtStat;
      logic [EVT_W-1:0] evtMask;
      logic irq;
      logic [ID_W-1:0] irqId;
      logic evtIrq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pic_state_t;

   typedef struct packed {
      logic [NUM_SRC-1:0] s1;
      logic [NUM_SRC-1:0] s2;
   } pic_sync_t;
endpackage : pic_pkg

// ### rtl/pic_sync.sv
// Two-stage synchroniser for the interrupt source pins.
`timescale 1ns/1ns
`default_nettype none
module pic_sync
   import pic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [NUM_SRC-1:0] din,
   output logic [NUM_SRC-1:0] dout
);
   pic_sync_t st_r;
   pic_sync_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign dout = st_r.s2;
endmodule : pic_sync
`default_nettype wire

// ### rtl/pic_arbiter.sv
// Priority selection and preemption decision over all sources.
`timescale 1ns/1ns
`default_nettype none
module pic_arbiter
   import pic_pkg::*;
(
   input wire logic [NUM_SRC-1:0] req,
   input wire logic [NUM_SRC-1:0][PRIO_BITS-1:0] prio,
   input wire logic [NUM_SRC-1:0] active,
   input wire logic [PRIO_BITS-1:0] thresh,
   input wire logic [2:0] groupBits,
   output logic found,
   output logic [ID_W-1:0] bestId,
   output logic preempt
);
   logic [NUM_SRC-1:0] elig;
   logic [2:0] effPb;
   logic [PRIO_BITS-1:0] gmask;
   logic [PRIO_BITS-1:0] bestP;
   logic [3:0] runP;

   // =========================================================
   // Threshold gate per source
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign elig[i] = req[i] &&
         !((thresh != '0) && (prio[i] >= thresh)); // RL12 RL13 RL11
   end

   // Settings past the implemented width all act as full preemption.
   assign effPb = (groupBits >= PB_MAX) ? PB_MAX : groupBits; // RL9
   assign gmask = {PRIO_BITS{1'b1}} << (PB_MAX - effPb); // RL8

   // =========================================================
   // Selection
   always_comb begin
      found = 1'b0;
      bestId = '0;
      bestP = '0;
      runP = RUN_IDLE;
      // Descending scan so that a tie keeps the lower source number.
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (elig[i] && (!found || prio[i] <= bestP)) begin // RL10 RL15
            found = 1'b1;
            bestP = prio[i];
            bestId = ID_W'(i);
         end
         if (active[i] && ({1'b0, prio[i] & gmask} < runP)) begin
            runP = {1'b0, prio[i] & gmask};
         end
      end
      // Equal preemption groups wait for the running handler to end.
      preempt = found && ({1'b0, bestP & gmask} < runP); // RL6 RL16
   end
endmodule : pic_arbiter
`default_nettype wire

// ### rtl/pic_ctrl.sv
// Prioritized nestable interrupt controller with an APB register port.
// Function
// RL1 - Each source has its own software enable, separate from peripheral enables.
// RL2 - A global mask gates only the single request and leaves enables alone.
// RL3 - Software can read whether the global mask was set before its last change; the code keeps the value from before the last write to it.
// RL4 - Clearing a pending bit discards the waiting request of that source.
// RL5 - Software can force a source pending and it is taken when priority allows.
// RL6 - A less urgent pending source waits until the running handler ends.
// RL7 - A pending source is dispatched only while its enable is set.
// RL8 - A grouping value splits priority into preemption and subpriority bits.
// RL9 - Grouping values from three to seven behave the same.
// RL10 - A smaller priority number is more urgent and zero is the most urgent.
// RL11 - Only the upper three bits of each priority take part in arbitration.
// RL12 - A threshold blocks every source at or numerically above it.
// RL13 - A threshold of zero blocks nothing.
// RL14 - There are thirty-two sources and eight priority levels.
// RL15 - Among equal priorities the lowest source number is taken first.
// RL16 - Equal preemption groups never preempt each other and run back to back.
// RL17 - Each priority field is eight bits with the low five reading as zero.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl
   import pic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NUM_SRC-1:0] srcIrq,
   input wire logic cpuAck,
   input wire logic cpuEoi,
   input wire logic [ID_W-1:0] cpuEoiId,
   output logic cpuIrq,
   output logic [ID_W-1:0] cpuIrqId,
   output logic evtIrq
);
   pic_state_t st_r;
   pic_state_t st_nxt;
   logic [NUM_SRC-1:0] srcSync;
   logic [NUM_SRC-1:0] srcRise;
   logic [NUM_SRC-1:0] ackV;
   logic [NUM_SRC-1:0] eoiV;
   logic [NUM_SRC-1:0] pset;
   logic [NUM_SRC-1:0] pclr;
   logic [EVT_W-1:0] evtSet;
   logic [EVT_W-1:0] evtClr;
   logic [31:0] rdVal;
   logic [ID_W-1:0] pIdx;
   logic setup;
   logic acc;
   logic wr;
   logic isPrio;
   logic mapped;
   logic arbFound;
   logic arbPreempt;
   logic [ID_W-1:0] arbId;

   // =========================================================
   // Source pins and arbitration
   pic_sync u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .din(srcIrq),
      .dout(srcSync)
   );

   pic_arbiter u_arb (
      .req(st_r.pending & st_r.enable), // RL7
      .prio(st_r.prio),
      .active(st_r.active),
      .thresh(st_r.thresh),
      .groupBits(st_r.groupBits),
      .found(arbFound),
      .bestId(arbId),
      .preempt(arbPreempt)
   );

   // =========================================================
   // Next state
   always_comb begin
      st_nxt = st_r;
      setup = psel && penable && !st_r.pready;
      acc = psel && penable && st_r.pready;
      wr = acc && pwrite;
      isPrio = paddr[PRIO_SEL_BIT];
      pIdx = paddr[PRIO_IDX_MSB:PRIO_IDX_LSB];
      srcRise = srcSync & ~st_r.srcPrev;
      ackV = (cpuAck && st_r.irq) ? (ONE_SRC << st_r.irqId) : '0;
      eoiV = cpuEoi ? (ONE_SRC << cpuEoiId) : '0;
      pset = '0;
      pclr = '0;
      mapped = 1'b1;
      rdVal = '0;
      // Read mux.
      case (paddr)
         OFF_ENABLE, OFF_ENSET, OFF_ENCLR: rdVal = st_r.enable;
         OFF_PENDSET, OFF_PENDCLR: rdVal = st_r.pending;
         OFF_ACTIVE: rdVal = st_r.active;
         OFF_MASTER: rdVal = 32'({st_r.masterPrev, st_r.masterMask}); // RL3
         OFF_GROUP: rdVal = 32'(st_r.groupBits); // RL8
         OFF_THRESH: rdVal = 32'({st_r.thresh, PRIO_LOW_ZERO});
         OFF_EVTSTAT: rdVal = 32'(st_r.evtStat);
         OFF_EVTMASK: rdVal = 32'(st_r.evtMask);
         default: mapped = 1'b0;
      endcase
      if (isPrio) begin
         mapped = 1'b1;
         rdVal = 32'({st_r.prio[pIdx], PRIO_LOW_ZERO}); // RL17
      end
      st_nxt.pready = setup;
      st_nxt.pslverr = setup && !mapped;
      st_nxt.prdata = (setup && !pwrite && mapped) ? rdVal : '0;
      // Writes take effect only at the completing edge.
      if (wr && isPrio) begin
         st_nxt.prio[pIdx] = pwdata[PRIO_HI_MSB:PRIO_HI_LSB]; // RL11 RL17
      end else if (wr) begin
         case (paddr)
            OFF_ENABLE: st_nxt.enable = pwdata; // RL1
            OFF_ENSET: st_nxt.enable = st_r.enable | pwdata; // RL1
            OFF_ENCLR: st_nxt.enable = st_r.enable & ~pwdata; // RL1
            OFF_PENDSET: pset = pwdata; // RL5
            OFF_PENDCLR: pclr = pwdata; // RL4
            OFF_MASTER: begin
               st_nxt.masterPrev = st_r.masterMask; // RL3
               st_nxt.masterMask = pwdata[MASTER_MASK_BIT]; // RL2
            end
            OFF_GROUP: st_nxt.groupBits = pwdata[GROUP_MSB:0]; // RL8
            OFF_THRESH: st_nxt.thresh = pwdata[PRIO_HI_MSB:PRIO_HI_LSB];
            OFF_EVTMASK: st_nxt.evtMask = pwdata[EVT_W-1:0];
            default: st_nxt.thresh = st_r.thresh;
         endcase
      end
      // A new edge on the same cycle as a clear stays pending.
      st_nxt.srcPrev = srcSync;
      st_nxt.pending = (st_r.pending & ~pclr & ~ackV) | srcRise | pset; // RL4 RL5
      st_nxt.active = (st_r.active | ackV) & ~eoiV;
      evtSet = '0;
      evtSet[EVT_DISPATCH] = cpuAck && st_r.irq;
      evtSet[EVT_BADEOI] = cpuEoi && !st_r.active[cpuEoiId];
      evtSet[EVT_OVERRUN] = |(srcRise & st_r.pending);
      // Only bits already returned by the read are cleared.
      evtClr = (acc && !pwrite && paddr == OFF_EVTSTAT) ?
         st_r.prdata[EVT_W-1:0] : '0;
      st_nxt.evtStat = (st_r.evtStat & ~evtClr) | evtSet;
      st_nxt.evtIrq = |(st_nxt.evtStat & st_nxt.evtMask);
      // The request drops for one cycle after an acknowledge so the
      // taken source is never offered twice.
      st_nxt.irq = arbFound && arbPreempt && !st_r.masterMask && // RL2 RL6
         !(cpuAck && st_r.irq);
      st_nxt.irqId = arbId;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.prdata;
   assign pready = st_r.pready;
   assign pslverr = st_r.pslverr;
   assign cpuIrq = st_r.irq;
   assign cpuIrqId = st_r.irqId;
   assign evtIrq = st_r.evtIrq;

   // =========================================================
   // Checks
   a_enable_set: assert property ( // RL1
      @(posedge clk_sys) disable iff (!rst_n)
      (acc && pwrite && paddr == OFF_ENSET) |=>
      (st_r.enable == ($past(st_r.enable) | $past(pwdata))))
   else $error("Enable set write lost bits.");

   a_master_gate: assert property ( // RL2
      @(posedge clk_sys) disable iff (!rst_n)
      (st_r.masterMask && $past(st_r.masterMask)) |-> !cpuIrq)
   else $error("Request raised while globally masked.");

   a_master_keeps: assert property ( // RL2
      @(posedge clk_sys) disable iff (!rst_n)
      (acc && pwrite && paddr == OFF_MASTER) |=> $stable(st_r.enable))
   else $error("Global mask write changed source enables.");

   a_master_prev: assert property ( // RL3
      @(posedge clk_sys) disable iff (!rst_n)
      (acc && pwrite && paddr == OFF_MASTER) |=>
      (st_r.masterPrev == $past(st_r.masterMask)))
   else $error("Previous mask state not recorded.");

   a_pend_drop: assert property ( // RL4
      @(posedge clk_sys) disable iff (!rst_n)
      (acc && pwrite && paddr == OFF_PENDCLR && pwdata == '1 &&
       srcRise == '0) |=> (st_r.pending == '0) ##1 !cpuIrq)
   else $error("Cleared pending request survived.");

   a_pend_force: assert property ( // RL5
      @(posedge clk_sys) disable iff (!rst_n)
      (acc && pwrite && paddr == OFF_PENDSET) |=>
      ((st_r.pending & $past(pwdata)) == $past(pwdata)))
   else $error("Forced pending bit not set.");

   a_no_preempt: assert property ( // RL6
      @(posedge clk_sys) disable iff (!rst_n)
      cpuIrq |-> $past(arbPreempt))
   else $error("Request offered without preemption right.");

   a_enable_needed: assert property ( // RL7
      @(posedge clk_sys) disable iff (!rst_n)
      cpuIrq |-> (($past(st_r.enable) >> cpuIrqId) & ONE_SRC) != '0)
   else $error("Disabled source dispatched.");

   a_group_read: assert property ( // RL8
      @(posedge clk_sys) disable iff (!rst_n)
      (setup && !pwrite && paddr == OFF_GROUP) |=>
      (prdata == 32'(st_r.groupBits)) && pready)
   else $error("Grouping readback wrong.");

   a_prio_low: assert property ( // RL17
      @(posedge clk_sys) disable iff (!rst_n)
      (setup && !pwrite && isPrio) |=>
      (prdata[PRIO_LOW_W-1:0] == '0) && (prdata[31:PRIO_FIELD_W] == '0))
   else $error("Priority low bits not zero.");

   a_threshold: assert property ( // RL12
      @(posedge clk_sys) disable iff (!rst_n)
      (cpuIrq && $stable(st_r.thresh) && $stable(st_r.prio)) |->
      (st_r.thresh == '0 || st_r.prio[cpuIrqId] < st_r.thresh))
   else $error("Source at or above threshold dispatched.");

   a_enable_write: assert property ( // RL1
      @(posedge clk_sys) disable iff (!rst_n)
      (wr && paddr == OFF_ENABLE) |=> (st_r.enable == $past(pwdata)))
   else $error("Enable write not stored.");

   a_enable_clr: assert property ( // RL1
      @(posedge clk_sys) disable iff (!rst_n)
      (wr && paddr == OFF_ENCLR) |=>
      ((st_r.enable & $past(pwdata)) == '0))
   else $error("Enable clear write left bits set.");

   a_master_write: assert property ( // RL2
      @(posedge clk_sys) disable iff (!rst_n)
      (wr && paddr == OFF_MASTER) |=>
      (st_r.masterMask == $past(pwdata[MASTER_MASK_BIT])))
   else $error("Global mask write not stored.");

   a_pend_clear: assert property ( // RL4
      @(posedge clk_sys) disable iff (!rst_n)
      (wr && paddr == OFF_PENDCLR) |=>
      ((st_r.pending & $past(pwdata) & ~$past(srcRise)) == '0))
   else $error("Cleared pending bit stayed set.");

   a_idle_dispatch: assert property ( // RL5
      @(posedge clk_sys) disable iff (!rst_n)
      (arbFound && st_r.active == '0 && !st_r.masterMask &&
       !(cpuAck && st_r.irq)) |=> cpuIrq)
   else $error("Waiting source not offered to an idle core.");

   a_ack_taken: assert property ( // RL5
      @(posedge clk_sys) disable iff (!rst_n)
      (cpuAck && cpuIrq && !cpuEoi) |=>
      (!cpuIrq && ((st_r.active & $past(ackV)) != '0)))
   else $error("Taken source not moved to running.");

   a_eoi_clears: assert property ( // RL6
      @(posedge clk_sys) disable iff (!rst_n)
      cpuEoi |=> ((st_r.active & $past(eoiV)) == '0))
   else $error("Finished handler still marked running.");

   a_disabled_kept: assert property ( // RL7
      @(posedge clk_sys) disable iff (!rst_n)
      (!(wr && paddr == OFF_PENDCLR) && !cpuAck) |=>
      (($past(st_r.pending) & ~$past(st_r.enable) & ~st_r.pending) == '0))
   else $error("Disabled pending source was dropped.");

   a_pick_valid: assert property ( // RL7
      @(posedge clk_sys) disable iff (!rst_n)
      arbFound |->
      ((((st_r.pending & st_r.enable) >> arbId) & ONE_SRC) != '0))
   else $error("Arbiter picked a source without a request.");

   a_group_write: assert property ( // RL8
      @(posedge clk_sys) disable iff (!rst_n)
      (wr && paddr == OFF_GROUP) |=>
      (st_r.groupBits == $past(pwdata[GROUP_MSB:0])))
   else $error("Grouping write not stored.");

   a_thresh_write: assert property ( // RL11
      @(posedge clk_sys) disable iff (!rst_n)
      (wr && paddr == OFF_THRESH) |=>
      (st_r.thresh == $past(pwdata[PRIO_HI_MSB:PRIO_HI_LSB])))
   else $error("Threshold write not stored from the upper bits.");

   a_thresh_block: assert property ( // RL12
      @(posedge clk_sys) disable iff (!rst_n)
      (st_r.thresh != '0 && arbFound) |->
      (st_r.prio[arbId] < st_r.thresh))
   else $error("Arbiter picked a source at or above the threshold.");

   a_thresh_off: assert property ( // RL13
      @(posedge clk_sys) disable iff (!rst_n)
      (st_r.thresh == '0 && (st_r.pending & st_r.enable) != '0) |->
      arbFound)
   else $error("Zero threshold blocked a request.");
endmodule : pic_ctrl
`default_nettype wire

// ### sim/pic_core_model.sv
// Behavioural processor core that takes and finishes handlers.
`timescale 1ns/1ns
`default_nettype none
module pic_core_model
   import pic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cpuIrq,
   input wire logic [ID_W-1:0] cpuIrqId,
   input wire logic ackEn,
   input wire logic eoiGo,
   output logic cpuAck,
   output logic cpuEoi,
   output logic [ID_W-1:0] cpuEoiId,
   output logic [ID_W-1:0] takenId,
   output int takenCnt
);
   // =========================================================
   // Handler stack
   // A slow core is modelled by the bench driving ackEn low on random cycles, about one in three.
   logic [ID_W-1:0] stack [0:31];
   int depth;
   assign cpuAck = cpuIrq & ackEn;
   always @(posedge clk_sys) begin
      cpuEoi <= 1'b0;
      // Outside an end of handler the id lines invert on every clock.
      cpuEoiId <= ~cpuEoiId;
      if (!rst_n) begin
         depth <= 0;
         takenCnt <= 0;
         cpuEoiId <= 5'h00;
      end else if (cpuAck) begin
         stack[depth] <= cpuIrqId;
         depth <= depth + 1;
         takenId <= cpuIrqId;
         takenCnt <= takenCnt + 1;
      end else if (eoiGo && depth > 0 && !cpuEoi) begin
         cpuEoi <= 1'b1;
         cpuEoiId <= stack[depth-1];
         depth <= depth - 1;
      end
   end
endmodule : pic_core_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench of the prioritized interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import pic_pkg::*;
;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, ackEn = 1'b1, eoiGo = 1'b0;
   logic cpuAck, cpuEoi, cpuIrq, pready, pslverr, evtIrq;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic [NUM_SRC-1:0] srcIrq = 32'h0;
   logic [ID_W-1:0] cpuEoiId, cpuIrqId, takenId;
   int takenCnt, fails = 0, totalChecks = 0, seed = 32'hcc343815;

   pic_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .srcIrq(srcIrq), .cpuAck(cpuAck), .cpuEoi(cpuEoi),
      .cpuEoiId(cpuEoiId), .cpuIrq(cpuIrq), .cpuIrqId(cpuIrqId),
      .evtIrq(evtIrq));
   pic_core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n),
      .cpuIrq(cpuIrq), .cpuIrqId(cpuIrqId), .ackEn(ackEn),
      .eoiGo(eoiGo), .cpuAck(cpuAck), .cpuEoi(cpuEoi),
      .cpuEoiId(cpuEoiId), .takenId(takenId), .takenCnt(takenCnt));

   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) ackEn <= $random(seed) % 3 != 0;

   // =========================================================
   // Bus and core tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      totalChecks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
      if (n >= 20) chk(32'h0, 32'h1);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic e;
      apb(1'b1, a, d, e);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      logic e;
      apb(1'b0, a, 32'h0, e);
      chk(rdv, x);
   endtask : rdc
   task automatic take(input int id);
      int c, n;
      c = takenCnt;
      n = 0;
      while (takenCnt == c && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      chk(takenCnt != c ? 32'(takenId) : 32'hbad, id);
   endtask : take
   task automatic noTake(input int n);
      int c;
      c = takenCnt;
      repeat (n) @(posedge clk_sys);
      chk(takenCnt - c, 32'h0);
   endtask : noTake
   task automatic eoi;
      int n;
      n = 0;
      eoiGo <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (cpuEoi !== 1'b1 && n < 20);
      eoiGo <= 1'b0;
      @(posedge clk_sys);
      if (n >= 20) chk(32'h0, 32'h1);
   endtask : eoi
   function automatic int best(int a, logic [7:0] pa, int b,
         logic [7:0] pb);
      if (pa[7:5] != pb[7:5]) return pa[7:5] < pb[7:5] ? a : b;
      return a < b ? a : b;
   endfunction : best
   task automatic finish_test;
      $display("checks %0d mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test

   initial begin
      #(50 * 40000);
      fails++;
      finish_test;
   end

   // =========================================================
   // Main sequence
   initial begin
      int a, b, g;
      logic [7:0] pa, pb;
      logic [31:0] rnd, en;
      logic e;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      rdc(OFF_MASTER, 32'h0);
      rdc(OFF_GROUP, 32'h0);
      rdc(OFF_EVTSTAT, 32'h0);
      apb(1'b0, 8'h2c, 32'h0, e);
      chk(e, 32'h1);
      for (a = 0; a < NUM_SRC; a++) begin
         rnd = $random(seed);
         wr(8'h80 + 8'(4 * a), rnd);
         rdc(8'h80 + 8'(4 * a), rnd & 32'he0);
      end
      rnd = $random(seed);
      en = (rnd | 32'hf0) & ~32'h3;
      wr(OFF_ENABLE, rnd);
      wr(OFF_ENSET, 32'hf0);
      wr(OFF_ENCLR, 32'h3);
      rdc(OFF_ENSET, en);
      wr(OFF_MASTER, 32'h1);
      rdc(OFF_MASTER, 32'h1);
      wr(OFF_MASTER, 32'h1);
      rdc(OFF_MASTER, 32'h3);
      rdc(OFF_ENABLE, en);
      wr(OFF_PENDSET, 32'hffffffff);
      noTake(8);
      rdc(OFF_PENDSET, 32'hffffffff);
      wr(OFF_PENDCLR, 32'hffffffff);
      wr(OFF_MASTER, 32'h0);
      rdc(OFF_MASTER, 32'h2);
      noTake(8);
      wr(OFF_ENABLE, 32'hffffffff);
      $display("test registers done");
      wr(OFF_ENCLR, 32'h40);
      wr(OFF_PENDSET, 32'h40);
      noTake(8);
      wr(OFF_PENDCLR, 32'h40);
      wr(OFF_ENSET, 32'h40);
      noTake(8);
      wr(OFF_EVTMASK, 32'h7);
      rdc(OFF_EVTMASK, 32'h7);
      wr(OFF_PENDSET, 32'h40);
      take(6);
      eoi;
      repeat (2) @(posedge clk_sys);
      chk(evtIrq, 32'h1);
      rdc(OFF_EVTSTAT, 32'h1);
      repeat (2) @(posedge clk_sys);
      chk(evtIrq, 32'h0);
      wr(OFF_EVTMASK, 32'h0);
      a = $random(seed) & 31;
      srcIrq <= ONE_SRC << a;
      take(a);
      eoi;
      noTake(8);
      chk(evtIrq, 32'h0);
      rdc(OFF_EVTSTAT, 32'h1);
      $display("test pending and events done");
      for (int t = 0; t < 8; t++) begin
         a = $random(seed) & 31;
         b = (a + 1 + ($random(seed) & 15)) & 31;
         pa = $random(seed);
         pb = $random(seed);
         if (t[0]) pb[7:5] = pa[7:5];
         wr(OFF_MASTER, 32'h1);
         wr(8'h80 + 8'(4 * a), {24'h0, pa});
         wr(8'h80 + 8'(4 * b), {24'h0, pb});
         wr(OFF_PENDSET, (ONE_SRC << a) | (ONE_SRC << b));
         noTake(4);
         wr(OFF_MASTER, 32'h0);
         take(best(a, pa, b, pb));
         noTake(8);
         eoi;
         take(a + b - best(a, pa, b, pb));
         eoi;
      end
      $display("test arbitration done");
      wr(8'h84, 32'h40);
      wr(8'h88, 32'h20);
      for (g = 0; g < 8; g++) begin
         wr(OFF_GROUP, g);
         rdc(OFF_GROUP, g);
         wr(OFF_PENDSET, 32'h2);
         take(1);
         wr(OFF_PENDSET, 32'h4);
         if (g >= 2) take(2);
         else noTake(8);
         eoi;
         if (g < 2) take(2);
         eoi;
      end
      $display("test grouping done");
      wr(8'h8c, 32'h80);
      wr(8'h90, 32'h60);
      wr(OFF_THRESH, 32'h9f);
      rdc(OFF_THRESH, 32'h80);
      wr(OFF_PENDSET, 32'h8);
      noTake(8);
      wr(OFF_PENDSET, 32'h10);
      take(4);
      eoi;
      wr(OFF_THRESH, 32'h0);
      take(3);
      eoi;
      $display("test threshold done");
      finish_test;
   end
endmodule : tb_top
`default_nettype wire
